//--- core/mld_top.sv
// Overview of operation
// - select bit: zero alarm, one melody
// - 12-bit divider, f = 32768/(2N+4)
// - melody run starts; clearing stops and clears
// - counter control: hold, run, clear, clear-run
// - counter control upper bit reads zero
// - running counter kept running on every write except clear
// - invert bit inverts alarm waveform
// - one-hot pattern, zero gives constant low
// - patterns modulated by 4096 Hz carrier
// - pattern two bursts 31.25 ms eight per second
// - rate requests 1..8192 Hz, status latching gated by enables
// - melody range 4 Hz to 8192 Hz
// - 15-bit free-run counter on low-speed clock
`default_nettype none
// ****************************************
// tone generator top
// ****************************************
module mld_top (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [mld_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [mld_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [mld_pkg::DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         lsclk_pin,
  output logic                              tone_out_pin,
  output logic                              irq,
  output logic      [mld_pkg::RATE_N-1:0]   rate_irq
);
  import mld_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mld_bus_e          bus;
    logic [DATA_W-1:0] rdata;
    logic [BYTE_W-1:0] pat;
    logic              frun;
    logic              inv;
    logic [3:0]        ctl_rsv;
    logic              sel;
    logic [MEL_W-1:0]  mel_n;
    logic              mrun;
    logic [MCNT_W-1:0] mcnt;
    logic              mwave;
    logic [IEN_W-1:0]  ien;
    logic [RATE_N-1:0] stat;
    logic [RATE_N-1:0] mask;
    logic [FRC_W-1:0]  frc;
    logic [RATE_N-1:0] rate;
    logic              tone;
    logic              irq;
  } mld_state_s;

  mld_state_s        st_ff;
  mld_state_s        nxt_st;
  logic              req;
  logic              acc;
  logic              wr_lo;
  logic [BYTE_W-1:0] wd;
  logic              ls_tick;
  logic              alarm_wave;
  logic              alarm_on;
  logic [MCNT_W-1:0] mel_last;

  // ****************************************
  // submodules
  // ****************************************
  mld_sync u_ls_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (lsclk_pin),
    .rise     (ls_tick)
  );

  mld_alarm_pat u_pat (
    .frc  (st_ff.frc),
    .pat  (st_ff.pat),
    .wave (alarm_wave)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign req             = avs_read | avs_write;
  assign acc             = req && (st_ff.bus == BUS_ACK);
  assign avs_waitrequest = req && (st_ff.bus != BUS_ACK);
  assign wr_lo           = acc && avs_write && avs_byteenable[0];
  assign wd              = avs_writedata[BYTE_W-1:0];
  assign mel_last        = {1'h0, st_ff.mel_n} + MEL_LAST;
  assign alarm_on        = alarm_wave & st_ff.frun;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [BYTE_W-1:0] rd;
    logic [1:0]        fc;
    rd          = RST_BYTE;
    fc          = FC_HOLD;
    nxt_st      = st_ff;
    nxt_st.rate = '0;

    // bus handshake, one wait cycle
    case (st_ff.bus)
      BUS_IDLE: begin
        if (req) begin
          nxt_st.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_st.bus = BUS_IDLE;
      end
      default: begin
        nxt_st.bus = BUS_IDLE;
      end
    endcase

    // read mux, unmapped reads zero
    if (reg_hit(avs_address, IDX_PAT)) begin
      rd = st_ff.pat;
    end else if (reg_hit(avs_address, IDX_CTL)) begin
      rd = {1'h0, st_ff.frun, st_ff.inv, st_ff.ctl_rsv, st_ff.sel};
    end else if (reg_hit(avs_address, IDX_MFL)) begin
      rd = st_ff.mel_n[MEL_LO_W-1:0];
    end else if (reg_hit(avs_address, IDX_MFH)) begin
      rd = {st_ff.mrun, 3'h0, st_ff.mel_n[MEL_W-1:MEL_LO_W]};
    end else if (reg_hit(avs_address, IDX_IEN)) begin
      rd = {2'h0, st_ff.ien};
    end else if (reg_hit(avs_address, IDX_STAT)) begin
      rd = {3'h0, st_ff.stat};
    end else if (reg_hit(avs_address, IDX_MASK)) begin
      rd = {3'h0, st_ff.mask};
    end
    if (req && (st_ff.bus == BUS_IDLE)) begin
      nxt_st.rdata = {{(DATA_W-BYTE_W){1'h0}}, rd};
    end

    // free-run counter and rate requests
    if (ls_tick && st_ff.frun) begin
      nxt_st.frc = st_ff.frc + FRC_W'(1);
      for (int i = 0; i < RATE_N; i++) begin
        // low bits wrap at each rate
        nxt_st.rate[i] = (nxt_st.frc & span_mask(0, $clog2(LS_HZ / RATE_HZ[i]))) == '0;
      end
    end

    // melody divider
    if (!st_ff.mrun) begin
      nxt_st.mcnt  = '0;
      nxt_st.mwave = 1'h0;
    end else if (ls_tick) begin
      if (st_ff.mcnt >= mel_last) begin
        nxt_st.mcnt  = '0;
        nxt_st.mwave = ~st_ff.mwave;
      end else begin
        nxt_st.mcnt = st_ff.mcnt + MCNT_W'(1);
      end
    end

    // register writes
    if (wr_lo && reg_hit(avs_address, IDX_PAT)) begin
      nxt_st.pat = wd;
    end
    if (wr_lo && reg_hit(avs_address, IDX_CTL)) begin
      fc = wd[CTL_FC_HI:CTL_FC_LO];
      if (st_ff.frun && (fc == FC_HOLD)) begin
        fc = FC_RUN;
      end
      case (fc)
        FC_HOLD: begin
          nxt_st.frun = 1'h0;
        end
        FC_RUN: begin
          nxt_st.frun = 1'h1;
        end
        FC_CLR: begin
          nxt_st.frc  = '0;
          nxt_st.frun = 1'h0;
          nxt_st.rate = '0;
        end
        FC_CLR_RUN: begin
          nxt_st.frc  = '0;
          nxt_st.frun = 1'h1;
          nxt_st.rate = '0;
        end
        default: begin
          nxt_st.frun = st_ff.frun;
        end
      endcase
      nxt_st.inv     = wd[CTL_INV];
      nxt_st.ctl_rsv = wd[CTL_RSV_HI:CTL_RSV_LO];
      nxt_st.sel     = wd[CTL_SEL];
    end
    if (wr_lo && reg_hit(avs_address, IDX_MFL)) begin
      nxt_st.mel_n[MEL_LO_W-1:0] = wd;
    end
    if (wr_lo && reg_hit(avs_address, IDX_MFH)) begin
      nxt_st.mrun                    = wd[MFH_RUN];
      nxt_st.mel_n[MEL_W-1:MEL_LO_W] = wd[MFH_N_HI:0];
    end
    if (wr_lo && reg_hit(avs_address, IDX_IEN)) begin
      nxt_st.ien = wd[IEN_W-1:0];
    end
    if (wr_lo && reg_hit(avs_address, IDX_MASK)) begin
      nxt_st.mask = wd[RATE_N-1:0];
    end

    // sticky status, set wins over clear
    nxt_st.stat = st_ff.stat;
    if (wr_lo && reg_hit(avs_address, IDX_STAT)) begin
      nxt_st.stat = st_ff.stat & ~wd[RATE_N-1:0];
    end
    nxt_st.stat = nxt_st.stat | (st_ff.rate & st_ff.ien[RATE_N-1:0]);
    nxt_st.irq  = |(st_ff.stat & st_ff.mask);

    // output pin
    nxt_st.tone = st_ff.sel ? st_ff.mwave : (alarm_on ^ st_ff.inv);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign tone_out_pin = st_ff.tone;
  assign irq          = st_ff.irq;
  assign rate_irq     = st_ff.rate;

  // ****************************************
  // checks
  // ****************************************
  default clocking mld_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_melody_route: assert property (
    (st_ff.sel && !st_ff.mrun) [*2] |=> !tone_out_pin)
    else $error("stopped melody route drives tone high");
  a_melody_wrap: assert property (
    (st_ff.mrun && ls_tick && (st_ff.mcnt >= mel_last) && !wr_lo)
    |=> (st_ff.mcnt == '0) && (st_ff.mwave != $past(st_ff.mwave)))
    else $error("melody divider did not wrap and toggle");
  a_melody_stop: assert property (
    !st_ff.mrun |=> (st_ff.mcnt == '0) && !st_ff.mwave)
    else $error("stopped melody counter not cleared");
  a_fc_clear: assert property (
    (wr_lo && reg_hit(avs_address, IDX_CTL) && (wd[CTL_FC_HI:CTL_FC_LO] == FC_CLR))
    |=> (st_ff.frc == '0) && !st_ff.frun)
    else $error("counter clear ignored");
  a_fc_hold: assert property (
    (!st_ff.frun && !wr_lo) |=> $stable(st_ff.frc))
    else $error("held counter moved");
  a_fc_hi_read: assert property (
    (acc && avs_read && reg_hit(avs_address, IDX_CTL)) |-> !avs_readdata[CTL_FC_HI])
    else $error("counter control upper bit read as one");
  a_keep_run: assert property (
    (st_ff.frun && wr_lo && reg_hit(avs_address, IDX_CTL) &&
     (wd[CTL_FC_HI:CTL_FC_LO] == FC_HOLD)) |=> st_ff.frun)
    else $error("running counter stopped by control write");
  a_invert_off: assert property (
    (!st_ff.sel && (st_ff.pat == PAT_OFF) && st_ff.inv) |=> tone_out_pin)
    else $error("inverted silent alarm not high");
  a_pat_zero: assert property (
    (!st_ff.sel && (st_ff.pat == PAT_OFF) && !st_ff.inv) |=> !tone_out_pin)
    else $error("silent alarm pattern not low");
  a_carrier_low: assert property (
    (!st_ff.sel && (st_ff.pat == PAT_ONE) && !st_ff.inv && !st_ff.frc[CARRIER_BIT])
    |=> !tone_out_pin)
    else $error("alarm high in carrier low phase");
  a_burst_gap: assert property (
    (!st_ff.sel && (st_ff.pat == PAT_TWO) && !st_ff.inv &&
     (st_ff.frc[PAT_PERIOD_BIT[1]-1:PAT_BURST_BIT[1]] != '0)) |=> !tone_out_pin)
    else $error("pattern two sounds outside burst");
  a_rate_status: assert property (
    (st_ff.rate[0] && st_ff.ien[0]) |=> st_ff.stat[0])
    else $error("enabled rate request not latched");
  a_frc_step: assert property (
    (st_ff.frun && ls_tick && !wr_lo) |=> (st_ff.frc == $past(st_ff.frc) + 1'h1))
    else $error("free-run counter missed a tick");
  a_irq_level: assert property (
    (|(st_ff.stat & st_ff.mask)) |=> irq)
    else $error("unmasked status without interrupt");

  c_melody_toggle: cover property ($rose(st_ff.mwave));
  c_alarm_tone: cover property (!st_ff.sel && $rose(tone_out_pin));
  c_irq_rise: cover property ($rose(irq));
  c_ctl_write: cover property (wr_lo && reg_hit(avs_address, IDX_CTL));
endmodule
`default_nettype wire

//--- pkg/mld_pkg.sv
`default_nettype none
package mld_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned       ADDR_W   = 16;
  localparam int unsigned       DATA_W   = 32;
  localparam int unsigned       BYTE_W   = 8;
  localparam logic [ADDR_W-1:0] IDX_PAT  = 16'h1330;
  localparam logic [ADDR_W-1:0] IDX_CTL  = 16'h1331;
  localparam logic [ADDR_W-1:0] IDX_MFL  = 16'h1332;
  localparam logic [ADDR_W-1:0] IDX_MFH  = 16'h1333;
  localparam logic [ADDR_W-1:0] IDX_IEN  = 16'h1334;
  localparam logic [ADDR_W-1:0] IDX_STAT = 16'h1335;
  localparam logic [ADDR_W-1:0] IDX_MASK = 16'h1336;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

  // ****************************************
  // field layout
  // ****************************************
  localparam int CTL_FC_HI  = 7;
  localparam int CTL_FC_LO  = 6;
  localparam int CTL_INV    = 5;
  localparam int CTL_RSV_HI = 4;
  localparam int CTL_RSV_LO = 1;
  localparam int CTL_SEL    = 0;
  localparam int MFH_RUN    = 7;
  localparam int MFH_N_HI   = 3;
  localparam int MEL_LO_W   = 8;
  localparam int MEL_W      = 12;
  localparam int MCNT_W     = 13;
  localparam int IEN_W      = 6;
  localparam int RATE_N     = 5;
  localparam int FRC_W      = 15;
  localparam int PAT_N      = 8;

  localparam logic [1:0]        FC_HOLD    = 2'h0;
  localparam logic [1:0]        FC_RUN     = 2'h1;
  localparam logic [1:0]        FC_CLR     = 2'h2;
  localparam logic [1:0]        FC_CLR_RUN = 2'h3;
  localparam logic [MCNT_W-1:0] MEL_LAST   = 13'h0001;
  localparam logic [BYTE_W-1:0] PAT_OFF    = 8'h00;
  localparam logic [BYTE_W-1:0] PAT_ONE    = 8'h01;
  localparam logic [BYTE_W-1:0] PAT_TWO    = 8'h02;

  // ****************************************
  // rates, all from the low-speed clock
  // ****************************************
  localparam int LS_HZ          = 32768;
  localparam int CARRIER_HZ     = 4096;
  localparam int CARRIER_BIT    = $clog2(LS_HZ / CARRIER_HZ) - 1;
  localparam int RATE_HZ [RATE_N] = '{8192, 512, 64, 2, 1};
  localparam int PAT_BURST_BIT  [PAT_N] = '{15, 10, 11, 12, 13, 9, 8, 11};
  localparam int PAT_PERIOD_BIT [PAT_N] = '{15, 12, 13, 14, 15, 12, 11, 15};

  typedef enum logic [0:0] {
    BUS_IDLE = 1'h0,
    BUS_ACK  = 1'h1
  } mld_bus_e;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
    return {idx[ADDR_W-3:0], 2'h0};
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] idx);
    return a == reg_addr(idx);
  endfunction

  function automatic logic [FRC_W-1:0] span_mask(input int lo, input int hi);
    logic [FRC_W-1:0] m;
    m = '0;
    for (int b = 0; b < FRC_W; b++) begin
      m[b] = (b >= lo) && (b < hi);
    end
    return m;
  endfunction
endpackage
`default_nettype wire

//--- core/mld_sync.sv
`default_nettype none
// ****************************************
// low-speed clock pin synchroniser
// ****************************************
module mld_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      rise
);
  import mld_pkg::*;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
  } mld_sync_s;

  mld_sync_s st_ff;
  mld_sync_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sh   = {st_ff.sh[1:0], async_in};
    nxt_st.rise = 1'h0;
    if (st_ff.sh[2] == st_ff.sh[1]) begin
      nxt_st.lvl  = st_ff.sh[2];
      nxt_st.rise = st_ff.sh[2] & ~st_ff.lvl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise = st_ff.rise;

  a_rise_single: assert property (@(posedge clk) disable iff (rst)
    st_ff.rise |=> !st_ff.rise)
    else $error("low-speed edge pulse longer than one cycle");
endmodule
`default_nettype wire

//--- core/mld_alarm_pat.sv
`default_nettype none
// ****************************************
// alarm pattern waveform
// ****************************************
module mld_alarm_pat (
  input  wire logic [mld_pkg::FRC_W-1:0]  frc,
  input  wire logic [mld_pkg::BYTE_W-1:0] pat,
  output logic                            wave
);
  import mld_pkg::*;

  always_comb begin
    wave = 1'h0;
    for (int k = 0; k < PAT_N; k++) begin
      if (pat == BYTE_W'(1 << k)) begin
        // 4096 Hz carrier gated into bursts
        wave = frc[CARRIER_BIT] &
               ((frc & span_mask(PAT_BURST_BIT[k], PAT_PERIOD_BIT[k])) == '0);
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/mld_speaker.sv
`default_nettype none
// ****************************************
// loudspeaker on the tone pin: measures half periods in low-speed ticks
// ****************************************
module mld_speaker (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tone,
  input  wire logic lsclk,
  output int        half_ticks,
  output int        edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ls_q;
  logic tone_q;
  int   cnt;
  always @(posedge clk) begin
    if (rst) begin
      ls_q       <= 1'b0;
      tone_q     <= 1'b0;
      cnt        <= 0;
      half_ticks <= 0;
      edges      <= 0;
    end else begin
      ls_q   <= lsclk;
      tone_q <= tone;
      if (tone !== tone_q) begin
        half_ticks <= cnt;
        cnt        <= 0;
        edges      <= edges + 1;
      end else if (lsclk && !ls_q) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/test_melody_alarm_tone_generator.sv
`default_nettype none
module test_melody_alarm_tone_generator;
  import mld_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              rd_en = 1'b0;
  logic              wr_en = 1'b0;
  logic              lsclk_pin = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rdat;
  logic [3:0]        be = 4'hF;
  logic              wreq;
  logic              tone;
  logic              irq;
  logic [RATE_N-1:0] rate_irq;
  int                errors = 0;
  int                cmp_count = 0;
  int                ticks = 0;
  int                ls_div = 0;
  int                half;
  int                edges;
  int                regm [8] = '{default: 0};
  int                run_m = 0;

  mld_top dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .lsclk_pin(lsclk_pin), .tone_out_pin(tone), .irq(irq), .rate_irq(rate_irq));
  mld_speaker spk (.clk(clk), .rst(rst), .tone(tone), .lsclk(lsclk_pin),
    .half_ticks(half), .edges(edges));

  // ****************************************
  // clocks: low-speed pin toggles every 5 cycles
  // ****************************************
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    ls_div <= (ls_div == 4) ? 0 : ls_div + 1;
    if (ls_div == 4) lsclk_pin <= ~lsclk_pin;
    if (ls_div == 4 && !lsclk_pin) ticks <= ticks + 1;
  end

  // ****************************************
  // checking and ending
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic timeout();
    errors++;
    report_and_stop();
  endtask

  // ****************************************
  // bus master and register model
  // ****************************************
  task automatic acc(input int i, input logic w, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    adr   <= (IDX_PAT + 16'(i)) << 2;
    rd_en <= !w;
    wr_en <= w;
    wdat  <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) timeout();
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] q;
    if (i == 1) begin
      if (d[7]) run_m = d[6];
      else if (d[6]) run_m = 1;
      regm[1] = d & 8'h3F;
    end else regm[i] = d;
    acc(i, 1'b1, d, q);
  endtask
  task automatic rd(input int i, input logic [31:0] e);
    logic [31:0] q;
    acc(i, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  function automatic logic [31:0] exp_rd(input int i);
    case (i)
      1: return 32'(regm[1] | (run_m << 6));
      3: return 32'(regm[3] & 8'h8F);
      4: return 32'(regm[4] & 8'h3F);
      6: return 32'(regm[6] & 8'h1F);
      7: return 32'h0;
      default: return 32'(regm[i]);
    endcase
  endfunction
  task automatic tone_half(input int e);
    int n;
    int e0;
    e0 = edges;
    n = 0;
    while (edges < e0 + 3 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 12000) timeout();
    chk(32'(half), 32'(e));
  endtask
  task automatic rate_gap(input int b, input int e);
    int n;
    int t0;
    n = 0;
    while (rate_irq[b] !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    t0 = ticks;
    @(posedge clk);
    while (rate_irq[b] !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 12000) timeout();
    chk(32'(ticks - t0), 32'(e));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (90000) @(posedge clk);
    timeout();
  end
  initial begin
    int nv [2];
    int e0;
    int t0;
    int n;
    void'($urandom(89258));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i, 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      wr(0, 8'h01 << ($urandom % 8));
      rd(0, exp_rd(0));
      wr(2, 8'($urandom));
      rd(2, exp_rd(2));
      wr(3, 8'($urandom) & 8'h7F);
      rd(3, exp_rd(3));
      wr(4, 8'h01 << ($urandom % 5));
      rd(4, exp_rd(4));
      wr(1, 8'($urandom) & 8'h21);
      rd(1, exp_rd(1));
    end
    wr(4, 8'h00);
    wr(1, 8'hC0);
    rd(1, exp_rd(1));
    wr(1, 8'h21);
    rd(1, exp_rd(1));
    wr(1, 8'h80);
    rd(1, exp_rd(1));
    wr(1, 8'h00);
    wr(1, 8'h80);
    wr(1, 8'h40);
    rd(1, exp_rd(1));
    wr(0, 8'h01);
    tone_half(4);
    // pattern two: one burst of carrier edges, then silence
    wr(0, 8'h00);
    wr(1, 8'hC0);
    e0 = edges;
    wr(0, 8'h02);
    t0 = ticks;
    tone_half(4);
    n = 0;
    while (ticks - t0 < 1100 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 12000) timeout();
    chk(32'(edges - e0), 32'(2 * CARRIER_HZ / 32));
    repeat (400) @(posedge clk);
    chk(32'(edges - e0), 32'(2 * CARRIER_HZ / 32));
    wr(1, 8'h20);
    rd(1, exp_rd(1));
    wr(0, 8'h00);
    repeat (40) @(posedge clk);
    chk(tone, 1'b1);
    wr(1, 8'h00);
    repeat (40) @(posedge clk);
    chk(tone, 1'b0);
    rate_gap(0, 4);
    rate_gap(1, 64);
    rate_gap(2, 512);
    wr(4, 8'h01);
    wr(6, 8'h01);
    repeat (200) @(posedge clk);
    chk(irq, 1'b1);
    rd(5, 32'h1);
    wr(6, 8'h00);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0);
    wr(4, 8'h00);
    wr(5, 8'h01);
    repeat (100) @(posedge clk);
    rd(5, 32'h0);
    wr(1, 8'h01);
    nv[0] = 1 + ($urandom % 20);
    nv[1] = 12'h105;
    foreach (nv[j]) begin
      wr(2, 8'(nv[j]));
      wr(3, 8'h80 | 8'(nv[j] >> 8));
      tone_half(nv[j] + 2);
    end
    wr(3, 8'h00);
    repeat (10) @(posedge clk);
    chk(tone, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
